// ===== design/page_reader_controller.sv
// Controller of an optical page reader: reading, mirror, locate, mark, advance
// What this block does
// R1 - Flag characters outside alpha/numeric set, code 0B
// R2 - Raise data interrupt when read data ready
// R3 - Line read done sets compare, done interrupt
// R4 - Unread word overrun records lost data, alarm
// R5 - Data ready status while word is waiting
// R6 - Each data word holds two characters
// R7 - Stop read halts; mirror gives stop coordinate
// R8 - Coordinate tracks characters within two positions
// R9 - Page advance by one to fifteen lines
// R10 - Zero mirror and move to coordinate
// R11 - Locate failure sets fail, alarm within limit
// R12 - Locate success sets done within limit
// R13 - Locate failure raises selected alarm interrupt
// R14 - Locate success raises selected done interrupt
// R15 - Mark page busy until marking ends
// R16 - Mark completion raises selected done interrupt
// R17 - Busy held for every operation's duration
`default_nettype none
module page_reader_controller #(
  parameter int LOCATE_CYCLES = page_reader_pkg::LOCATE_LIMIT_CYC,
  parameter int MARK_CYCLES   = 16,
  parameter int LINE_CYCLES   = 8,
  parameter int MOVE_CYCLES   = 1,
  parameter int LINE_END      = 8'hF0
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // Host function port
  input  wire logic                            cmdValid,
  input  wire page_reader_pkg::command_type    cmd,
  input  wire page_reader_pkg::mode_type       modeSel,
  input  wire page_reader_pkg::int_select_type intSel,
  input  wire logic                            dataTake,
  // Scanner and transport
  input  wire logic                            charValid,
  input  wire logic [7:0]                      charCode,
  input  wire logic                            lineFound,
  // Host outputs
  output logic [15:0]                          dataWord,
  output page_reader_pkg::status_type          status,
  output logic [7:0]                           errorCode,
  output logic [7:0]                           mirrorCoord,
  output logic [3:0]                           linesMoved,
  output logic                                 dataIrq,
  output logic                                 doneIrq,
  output logic                                 alarmIrq
);
  import page_reader_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {IDLE, READING, MOVING, LOCATING, MARKING, ADVANCING} state_type;
  state_type   state, next_state;
  logic [31:0] timer, next_timer;
  logic [7:0]  target, next_target;
  logic [7:0]  lowChar, next_lowChar;
  logic        haveLow, next_haveLow;
  logic [3:0]  advLeft, next_advLeft;
  logic [15:0] next_dataWord;
  status_type  next_status;
  logic [7:0]  next_errorCode, next_mirrorCoord;
  logic [3:0]  next_linesMoved;
  logic        next_dataIrq, next_doneIrq, next_alarmIrq;
  logic        inMode, isDigit, isLetter, lineEnd;

  assign isDigit  = (charCode >= 8'h30) && (charCode <= 8'h39);
  assign isLetter = (charCode >= 8'h41) && (charCode <= 8'h5A);
  assign lineEnd  = mirrorCoord == 8'(LINE_END);

  always_comb begin
    unique case (modeSel)
      MODE_ALPHA:   inMode = isLetter || charCode == 8'h20;
      MODE_NUMERIC: inMode = isDigit || charCode == 8'h20;
      default:      inMode = 1'b1;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_timer       = timer;
    next_target      = target;
    next_lowChar     = lowChar;
    next_haveLow     = haveLow;
    next_advLeft     = advLeft;
    next_dataWord    = dataWord;
    next_status      = status;
    next_errorCode   = errorCode;
    next_mirrorCoord = mirrorCoord;
    next_linesMoved  = linesMoved;
    next_dataIrq     = 1'b0;
    next_doneIrq     = 1'b0;
    next_alarmIrq    = 1'b0;
    if (dataTake) begin
      next_status.dataReady = 1'b0;
    end
    unique case (state)
      IDLE: begin
        if (cmdValid) begin
          unique case (cmd.op)
            FN_READ: begin
              next_state                = READING;
              next_status.busy          = 1'b1; // R17
              next_status.mirrorCompare = 1'b0;
              next_status.operationDone = 1'b0;
              next_status.lostData      = 1'b0;
              next_status.outOfMode     = 1'b0;
              next_haveLow              = 1'b0;
              next_timer                = '0;
            end
            FN_ZERO: begin
              next_state       = MOVING; // R10
              next_target      = COORD_ZERO;
              next_timer       = '0;
              next_status.busy = 1'b1;
            end
            FN_MOVE: begin
              next_state       = MOVING; // R10
              next_target      = cmd.coord;
              next_timer       = '0;
              next_status.busy = 1'b1;
            end
            FN_LOCATE: begin
              next_state                = LOCATING;
              next_timer                = '0;
              next_status.busy          = 1'b1;
              next_status.locateFail    = 1'b0;
              next_status.alarm         = 1'b0;
              next_status.operationDone = 1'b0;
            end
            FN_MARK: begin
              next_state                = MARKING; // R15
              next_timer                = '0;
              next_status.busy          = 1'b1;
              next_status.operationDone = 1'b0;
            end
            FN_ADVANCE: begin
              next_state       = ADVANCING; // R9
              next_advLeft     = (cmd.lines < ADVANCE_MIN) ? ADVANCE_MIN : cmd.lines;
              next_linesMoved  = '0;
              next_timer       = '0;
              next_status.busy = 1'b1;
            end
            FN_CLEAR: begin
              next_status = '0;
            end
            default: begin
            end
          endcase
        end
      end
      READING: begin
        next_timer = timer + 32'd1;
        if (cmdValid && cmd.op == FN_STOP) begin
          next_state       = IDLE; // R7
          next_status.busy = 1'b0;
        end else if (charValid) begin
          if (!inMode && modeSel != MODE_ALNUM) begin
            next_status.outOfMode = 1'b1; // R1
            next_errorCode        = OUT_OF_MODE_CODE; // R1
          end
          if (!haveLow) begin
            next_lowChar = charCode;
            next_haveLow = 1'b1;
          end else begin
            next_haveLow = 1'b0;
            next_dataWord = {lowChar, charCode}; // R6
            if (status.dataReady && !dataTake) begin
              next_status.lostData = 1'b1; // R4
              next_status.alarm    = 1'b1;
              next_alarmIrq        = intSel.alarmSel; // R4
            end
            next_status.dataReady = 1'b1; // R5
            next_dataIrq          = intSel.dataSel; // R2
          end
          // One coordinate step per character keeps registration exact
          next_mirrorCoord = mirrorCoord + 8'd1; // R8
        end
        if (!(cmdValid && cmd.op == FN_STOP) && lineEnd) begin
          next_state                = IDLE;
          next_status.busy          = 1'b0; // R17
          next_status.mirrorCompare = 1'b1; // R3
          next_status.operationDone = 1'b1;
          next_doneIrq              = intSel.doneSel; // R3
        end
      end
      MOVING: begin
        next_timer = timer + 32'd1;
        if (mirrorCoord == target) begin
          next_state                = IDLE;
          next_status.busy          = 1'b0;
          next_status.mirrorCompare = 1'b1;
          next_status.operationDone = 1'b1;
          next_doneIrq              = intSel.doneSel;
        end else if (timer >= 32'(MOVE_CYCLES - 1)) begin
          // One coordinate step every MOVE_CYCLES clocks
          next_timer = '0;
          if (mirrorCoord < target) begin
            next_mirrorCoord = mirrorCoord + 8'd1; // R10
          end else begin
            next_mirrorCoord = mirrorCoord - 8'd1; // R10
          end
        end
      end
      LOCATING: begin
        next_timer = timer + 32'd1;
        if (lineFound) begin
          next_state                = IDLE;
          next_status.busy          = 1'b0;
          next_status.operationDone = 1'b1; // R12
          next_doneIrq              = intSel.doneSel; // R14
        end else if (timer >= 32'(LOCATE_CYCLES - 2)) begin
          next_state             = IDLE;
          next_status.busy       = 1'b0;
          next_status.locateFail = 1'b1; // R11
          next_status.alarm      = 1'b1; // R11
          next_alarmIrq          = intSel.alarmSel; // R13
        end
      end
      MARKING: begin
        next_timer = timer + 32'd1;
        if (timer >= 32'(MARK_CYCLES - 1)) begin
          next_state                = IDLE;
          next_status.busy          = 1'b0; // R15
          next_status.operationDone = 1'b1;
          next_doneIrq              = intSel.doneSel; // R16
        end
      end
      ADVANCING: begin
        next_timer = timer + 32'd1;
        if (timer >= 32'(LINE_CYCLES - 1)) begin
          next_timer      = '0;
          next_linesMoved = linesMoved + 4'd1; // R9
          next_advLeft    = advLeft - 4'd1;
          if (advLeft == ADVANCE_MIN) begin
            next_state                = IDLE;
            next_status.busy          = 1'b0; // R17
            next_status.operationDone = 1'b1;
            next_doneIrq              = intSel.doneSel;
          end
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= IDLE;
      timer       <= '0;
      target      <= '0;
      lowChar     <= '0;
      haveLow     <= 1'b0;
      advLeft     <= '0;
      dataWord    <= '0;
      status      <= '0;
      errorCode   <= '0;
      mirrorCoord <= '0;
      linesMoved  <= '0;
      dataIrq     <= 1'b0;
      doneIrq     <= 1'b0;
      alarmIrq    <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      target      <= next_target;
      lowChar     <= next_lowChar;
      haveLow     <= next_haveLow;
      advLeft     <= next_advLeft;
      dataWord    <= next_dataWord;
      status      <= next_status;
      errorCode   <= next_errorCode;
      mirrorCoord <= next_mirrorCoord;
      linesMoved  <= next_linesMoved;
      dataIrq     <= next_dataIrq;
      doneIrq     <= next_doneIrq;
      alarmIrq    <= next_alarmIrq;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence readStart;
    state == IDLE && cmdValid && cmd.op == FN_READ;
  endsequence
  sequence markStart;
    state == IDLE && cmdValid && cmd.op == FN_MARK;
  endsequence

  out_of_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    state == READING && charValid && !inMode && modeSel != MODE_ALNUM && !(cmdValid && cmd.op == FN_STOP)
    |=> status.outOfMode && errorCode == OUT_OF_MODE_CODE) else $error("out of mode not flagged");
  data_irq_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    $rose(status.dataReady) && intSel.dataSel && $past(intSel.dataSel) |-> dataIrq)
    else $error("data interrupt missing");
  read_done_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    state == READING && lineEnd && !(cmdValid && cmd.op == FN_STOP)
    |=> status.mirrorCompare && !status.busy) else $error("read end not reported");
  lost_data_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    $rose(status.lostData) |-> status.alarm && status.dataReady) else $error("lost data not alarmed");
  ready_word_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    $rose(status.dataReady) |-> $past(charValid) && $past(haveLow) && $past(state) == READING)
    else $error("data ready without a word");
  word_pair_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    state == READING && charValid && haveLow && !(cmdValid && cmd.op == FN_STOP)
    |=> dataWord == {$past(lowChar), $past(charCode)}) else $error("word pairing wrong");
  stop_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    state == READING && cmdValid && cmd.op == FN_STOP |=> state == IDLE && $stable(mirrorCoord))
    else $error("stop read failed");
  locate_fail_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    state == LOCATING && !lineFound && timer >= 32'(LOCATE_CYCLES - 2)
    |=> status.locateFail && status.alarm && alarmIrq == $past(intSel.alarmSel)) else $error("locate fail");
  locate_ok_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    state == LOCATING && lineFound |=> status.operationDone && doneIrq == $past(intSel.doneSel))
    else $error("locate done missing");
  mark_busy_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
    markStart |=> status.busy [*2]) else $error("mark busy missing");
  read_busy_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
    readStart |=> status.busy && state == READING) else $error("read busy missing");
endmodule : page_reader_controller
`default_nettype wire

// ===== design/page_reader_pkg.sv
// Package: types and constants for the page reader controller
`default_nettype none
package page_reader_pkg;
  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int LOCATE_LIMIT_MS  = 300;
  localparam int LOCATE_LIMIT_CYC = LOCATE_LIMIT_MS * 1000 * CLK_MHZ;
  // --------------------------------------------------------------------------
  // Codes and widths
  // --------------------------------------------------------------------------
  localparam logic [7:0] OUT_OF_MODE_CODE = 8'h0B;
  localparam logic [3:0] ADVANCE_MIN      = 4'h1;
  localparam logic [7:0] COORD_ZERO       = 8'h00;
  localparam int         REG_SLIP         = 2;
  typedef enum logic [3:0] {
    FN_NONE, FN_READ, FN_STOP, FN_ZERO, FN_MOVE,
    FN_LOCATE, FN_MARK, FN_ADVANCE, FN_CLEAR
  } function_type;
  typedef enum logic [1:0] {MODE_ALNUM, MODE_ALPHA, MODE_NUMERIC} mode_type;
  // Host function request
  typedef struct packed {
    function_type op;
    logic [7:0]   coord;
    logic [3:0]   lines;
  } command_type;
  // Interrupt selections
  typedef struct packed {
    logic dataSel;
    logic doneSel;
    logic alarmSel;
  } int_select_type;
  // Host-visible status bits
  typedef struct packed {
    logic busy;
    logic dataReady;
    logic operationDone;
    logic alarm;
    logic lostData;
    logic locateFail;
    logic mirrorCompare;
    logic outOfMode;
  } status_type;
endpackage : page_reader_pkg
`default_nettype wire

// ===== tb/scan_model.sv
// Scanner stand-in that sends a row of characters, one every four cycles
`default_nettype none
module scan_model (
  // Clock
  input  wire logic        clk,
  // Row request
  input  wire logic        go,
  input  wire logic [3:0]  num,
  input  wire logic [63:0] text,
  // Character stream
  output logic             charValid,
  output logic [7:0]       charCode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  left;
  logic [63:0] row;
  logic [1:0]  gap;
  initial begin
    left = 4'h0;
    row = '0;
    gap = 2'd0;
    charValid = 1'b0;
    charCode = 8'h00;
  end
  always @(posedge clk) begin
    charValid <= 1'b0;
    // Idle line toggles so a stale code is never seen as held
    charCode <= ~charCode;
    if (go) begin
      left <= num;
      row <= text;
      gap <= 2'd0;
    end else if (left != 4'h0) begin
      gap <= gap + 2'd1;
      if (gap == 2'd3) begin
        charValid <= 1'b1;
        charCode <= row[63:56];
        row <= row << 8;
        left <= left - 4'h1;
      end
    end
  end
endmodule : scan_model
`default_nettype wire

// ===== tb/tb_page_reader_controller.sv
// Self-checking bench of the page reader controller
`default_nettype none
module tb_page_reader_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import page_reader_pkg::*;
  logic clk, rst_n, cmdValid, dataTake, charValid, lineFound, dataIrq, doneIrq, alarmIrq;
  logic go, takeEn, hit;
  command_type cmd;
  mode_type modeSel;
  int_select_type intSel;
  status_type status;
  logic [7:0] charCode, errorCode, mirrorCoord, c;
  logic [15:0] dataWord;
  logic [3:0] linesMoved, num, eff;
  logic [63:0] text;
  logic [15:0] expQ[$];
  integer seed;
  int num_errors, checks, cyc, nDone, nAlarm, nData, d, prevData;
  page_reader_controller #(.LOCATE_CYCLES(50)) page_reader_controller_inst (
    .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmd(cmd), .modeSel(modeSel), .intSel(intSel),
    .dataTake(dataTake), .charValid(charValid), .charCode(charCode), .lineFound(lineFound),
    .dataWord(dataWord), .status(status), .errorCode(errorCode), .mirrorCoord(mirrorCoord),
    .linesMoved(linesMoved), .dataIrq(dataIrq), .doneIrq(doneIrq), .alarmIrq(alarmIrq));
  scan_model scan_model_inst (.clk(clk), .go(go), .num(num), .text(text), .charValid(charValid),
    .charCode(charCode));
  always #5 clk = ~clk;
  // --------------------------------------------------------------------------
  // Compare tasks and host helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (exp !== got) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chkWord(input logic [15:0] got);
    if (expQ.size() == 0) chk("spare data word", 16'hFFFF, got);
    else chk("data word", expQ.pop_front(), got);
  endtask : chkWord
  task automatic issue(input function_type op, input logic [7:0] co, input logic [3:0] n);
    @(posedge clk);
    #1 cmd = '{op, co, n};
    cmdValid = 1'b1;
    @(posedge clk);
    #1 cmdValid = 1'b0;
  endtask : issue
  task automatic settle();
    cyc = 0;
    while (status.busy === 1'b1 && cyc < 2000) begin
      cyc++;
      @(posedge clk);
      #1;
    end
    if (cyc >= 2000) num_errors++;
    // One more edge so the one-cycle interrupt pulses get counted
    @(posedge clk);
    #1;
  endtask : settle
  task automatic readLine(input mode_type m, input logic [7:0] from, input logic [3:0] n);
    issue(FN_CLEAR, 8'h00, 4'h0);
    issue(FN_MOVE, from, 4'h0);
    settle();
    modeSel = m;
    issue(FN_READ, 8'h00, 4'h0);
    go = 1'b1;
    num = n;
    @(posedge clk);
    #1 go = 1'b0;
  endtask : readLine
  function automatic logic [7:0] chr(input logic dig);
    return dig ? 8'h30 + 8'({$random(seed)} % 10) : 8'h41 + 8'({$random(seed)} % 26);
  endfunction : chr
  task automatic test_done();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // Host side: takes each word at once unless takeEn is low
  always @(posedge clk) begin
    hit = (dataIrq === 1'b1) && takeEn;
    if (hit) begin
      chkWord(dataWord);
      chk("data ready", 16'h0001, {15'h0, status.dataReady});
    end
    #1 dataTake = hit;
  end
  always @(posedge clk) begin
    if (doneIrq === 1'b1) nDone++;
    if (alarmIrq === 1'b1) nAlarm++;
    if (dataIrq === 1'b1) nData++;
  end
  initial begin
    #300us;
    num_errors++;
    test_done();
  end
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    seed = 32'h9dcc_2fb4;
    {clk, rst_n, cmdValid, dataTake, lineFound, go, num, text} = '0;
    cmd = '0;
    modeSel = MODE_ALNUM;
    intSel = '1;
    takeEn = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    issue(FN_MOVE, 8'h02, 4'h0);
    settle();
    chk("move busy", 16'd3, 16'(cyc));
    chk("move coord", 16'h0002, {8'h00, mirrorCoord});
    chk("move compare", 16'h0001, {15'h0, status.mirrorCompare});
    chk("move irq", 16'd1, 16'(nDone));
    issue(FN_ZERO, 8'h00, 4'h0);
    settle();
    chk("zero coord", 16'h0000, {8'h00, mirrorCoord});
    d = nDone;
    issue(FN_MARK, 8'h00, 4'h0);
    chk("mark busy on", 16'h0001, {15'h0, status.busy});
    settle();
    chk("mark busy", 16'h0010, 16'(cyc));
    chk("mark irq", 16'(d + 1), 16'(nDone));
    for (int i = 0; i < 3; i++) begin
      num = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 + 4'({$random(seed)} % 14) : 4'hF;
      eff = (num == 4'h0) ? ADVANCE_MIN : num;
      issue(FN_ADVANCE, 8'h00, num);
      settle();
      chk("lines moved", 16'(eff), 16'(linesMoved));
      chk("advance busy", 16'(eff) * 16'h0008, 16'(cyc));
    end
    issue(FN_MOVE, 8'h25, 4'h0);
    settle();
    d = nAlarm;
    issue(FN_LOCATE, 8'h00, 4'h0);
    settle();
    chk("locate time", 16'h0001, 16'(cyc <= 50));
    chk("locate fail", 16'h0003, {14'h0, status.locateFail, status.alarm});
    chk("locate alarm irq", 16'(d + 1), 16'(nAlarm));
    d = nDone;
    issue(FN_LOCATE, 8'h00, 4'h0);
    repeat (3) @(posedge clk);
    #1 lineFound = 1'b1;
    settle();
    lineFound = 1'b0;
    chk("locate done", 16'h0002, {14'h0, status.operationDone, status.locateFail});
    chk("locate done irq", 16'(d + 1), 16'(nDone));
    for (int mi = 0; mi < 3; mi++) begin
      for (int k = 0; k < 8; k++) begin
        c = chr(mi == 2);
        if (k == 5) c = chr(mi != 2);
        text = {text[55:0], c};
      end
      for (int k = 0; k < 4; k++) expQ.push_back(text[63 - 16 * k -: 16]);
      d = nDone;
      prevData = nData;
      readLine(mode_type'(mi), 8'hE8, 4'h8);
      settle();
      chk("out of mode", 16'(mi != 0), {15'h0, status.outOfMode});
      if (mi != 0) chk("error code", {8'h00, OUT_OF_MODE_CODE}, {8'h00, errorCode});
      chk("read compare", 16'h0001, {15'h0, status.mirrorCompare});
      // The move to the start coordinate ends with a done pulse as well
      chk("read done irq", 16'(d + 2), 16'(nDone));
      chk("data irqs", 16'(prevData + 4), 16'(nData));
      chk("words left", 16'h0000, 16'(expQ.size()));
    end
    takeEn = 1'b0;
    d = nAlarm;
    readLine(MODE_ALNUM, 8'hE8, 4'h8);
    settle();
    chk("lost data", 16'h0003, {14'h0, status.lostData, status.alarm});
    chk("lost alarm irq", 16'h0001, 16'(nAlarm > d));
    takeEn = 1'b1;
    expQ.push_back(text[63:48]);
    readLine(MODE_ALNUM, 8'h10, 4'h2);
    repeat (12) @(posedge clk);
    issue(FN_STOP, 8'h00, 4'h0);
    settle();
    chk("stop busy", 16'h0000, {15'h0, status.busy});
    chk("stop coord", 16'h0012, {8'h00, mirrorCoord});
    test_done();
  end
endmodule : tb_page_reader_controller
`default_nettype wire
